// ===== logic/mpw_pkg.sv
// Purpose: Shared constants and types for the measurement period window block.
// Assumes: Four input elements, 16-bit signed samples.
// Notes:   Update interval codes and sync source codes are fixed here.
package mpw_pkg;

    localparam int NUM_ELEM   = 4;
    localparam int SAMPLE_W   = 16;
    localparam int CLK_HZ     = 50_000_000;
    // Crossing hysteresis as a percentage of the measurement range.
    localparam int HYST_PCT   = 5;
    localparam int PCT_FULL   = 100;

    // Data update interval selections.
    typedef enum logic [2:0] {
        UPD_50MS  = 3'h0,
        UPD_100MS = 3'h1,
        UPD_250MS = 3'h2,
        UPD_500MS = 3'h3,
        UPD_1S    = 3'h4,
        UPD_2S    = 3'h5,
        UPD_5S    = 3'h6,
        UPD_10S   = 3'h7
    } mpw_update_type;

    // Sync source selections: voltage or current of elements 1..4, ext, none.
    typedef enum logic [3:0] {
        SRC_VOLT1 = 4'h0, SRC_CURR1 = 4'h1,
        SRC_VOLT2 = 4'h2, SRC_CURR2 = 4'h3,
        SRC_VOLT3 = 4'h4, SRC_CURR3 = 4'h5,
        SRC_VOLT4 = 4'h6, SRC_CURR4 = 4'h7,
        SRC_EXT   = 4'h8, SRC_NONE  = 4'h9
    } mpw_src_type;
    localparam logic [3:0] SRC_LAST = 4'h9;

    // Element target: single element index or the collective choice.
    localparam logic [2:0] TGT_ALL  = 3'h4;

    typedef enum logic [1:0] {
        CREST_THREE = 2'b01,
        CREST_SIX   = 2'b10
    } mpw_crest_type;

    // Wiring system groups used when elements are not set independently.
    typedef enum logic [1:0] {
        WIRE_SINGLE = 2'h0,
        WIRE_PAIR   = 2'h1,
        WIRE_TRIPLE = 2'h2
    } mpw_wire_type;

    // Per-element window flags handed to the numeric computation.
    typedef struct packed {
        logic open;   // Samples now count toward normal results.
        logic start;  // One-cycle pulse at each interval end, as the next interval begins.
        logic close;  // One-cycle pulse, window closed, results valid.
        logic full;   // Window equalled the whole interval.
    } mpw_win_type;

endpackage

// ===== logic/mpw_top.sv
// Purpose: Measurement period window control for four input elements.
// Assumes: Samples arrive with sample_valid; update_tick marks interval ends.
// Notes:   Samples are not buffered; only a count of crossings, up to two, is kept per interval.
`timescale 1ns/1ps

module mpw_top
    import mpw_pkg::*;
(
    input  wire logic                             sys_clk,
    input  wire logic                             reset,
    input  wire logic                             sample_valid,
    input  wire logic [mpw_pkg::NUM_ELEM*2*mpw_pkg::SAMPLE_W-1:0] samples,
    input  wire logic [mpw_pkg::NUM_ELEM*mpw_pkg::SAMPLE_W-1:0]   range_full,
    input  wire logic                             ext_clk_in,
    input  wire logic                             update_tick,
    input  wire mpw_pkg::mpw_update_type          update_sel,
    input  wire logic                             falling_edge_sel,
    input  wire logic [mpw_pkg::NUM_ELEM-1:0]     installed,
    input  wire logic                             independent,
    input  wire mpw_pkg::mpw_wire_type            wiring,
    input  wire logic                             elem_step,
    input  wire logic                             elem_all,
    input  wire logic                             src_up,
    input  wire logic                             src_down,
    input  wire logic                             crest_sel_valid,
    input  wire mpw_pkg::mpw_crest_type           crest_sel,
    output mpw_pkg::mpw_win_type [mpw_pkg::NUM_ELEM-1:0] window,
    output logic [mpw_pkg::NUM_ELEM-1:0]          peak_window_open,
    output logic [2:0]                            target_elem,
    output logic [mpw_pkg::NUM_ELEM*4-1:0]        sync_src,
    output mpw_pkg::mpw_crest_type                crest_ratio,
    output logic                                  force_max_range
);
    import mpw_pkg::*;

    logic [2:0]          target_reg;
    mpw_src_type         src_reg [NUM_ELEM];
    mpw_crest_type       crest_reg;
    logic                force_reg;
    logic                ext_d_reg;
    logic [NUM_ELEM-1:0] open_reg;
    logic [NUM_ELEM-1:0] peak_reg;
    logic [NUM_ELEM-1:0] start_reg;
    logic [NUM_ELEM-1:0] close_reg;
    logic [NUM_ELEM-1:0] full_reg;
    logic                sync_mode;

    // Only the short and long intervals honour crossings at all.
    assign sync_mode = (update_sel == UPD_50MS)
                    || (update_sel == UPD_100MS)
                    || (update_sel == UPD_5S)
                    || (update_sel == UPD_10S);

    // Group size for stepping, set by the wiring system.
    function automatic logic [2:0] step_size(input mpw_wire_type w);
        case (w)
            WIRE_PAIR:   step_size = 3'h2;
            WIRE_TRIPLE: step_size = 3'h3;
            default:     step_size = 3'h1;
        endcase
    endfunction

    // Next installed element at or after a start index, wrapping round.
    function automatic logic [2:0] next_inst(input logic [2:0] from,
                                             input logic [NUM_ELEM-1:0] inst);
        logic [2:0] idx;
        next_inst = from;
        for (int k = NUM_ELEM - 1; k >= 0; k--) begin
            idx = 3'((32'(from) + k) % NUM_ELEM);
            if (inst[idx[1:0]]) begin
                next_inst = idx;
            end
        end
    endfunction

    // Target element stepping; the all choice leaves the cycle of elements.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            target_reg <= 3'h0;
        end else if (elem_all) begin
            target_reg <= TGT_ALL;
        end else if (elem_step) begin
            if (target_reg == TGT_ALL) begin
                target_reg <= next_inst(3'h0, installed);
            end else if (independent) begin
                target_reg <= next_inst(target_reg + 3'h1, installed);
            end else begin
                target_reg <= next_inst(3'((target_reg + step_size(wiring))
                                          % 3'h4), installed);
            end
        end
    end

    // A source is offered only when its element is installed.
    function automatic logic src_ok(input logic [3:0] s,
                                    input logic [NUM_ELEM-1:0] inst);
        src_ok = (s > SRC_LAST) ? 1'b0 : (s >= 4'(SRC_EXT)) ? 1'b1
                                        : inst[s[2:1]];
    endfunction

    function automatic logic [3:0] src_step(input logic [3:0] s,
                                            input logic up,
                                            input logic [NUM_ELEM-1:0] inst);
        logic [3:0] c;
        c = s;
        src_step = s;
        for (int k = 0; k <= int'(SRC_LAST); k++) begin
            if (up) begin
                c = (c == SRC_LAST) ? 4'h0 : c + 4'h1;
            end else begin
                c = (c == 4'h0) ? SRC_LAST : c - 4'h1;
            end
            if (src_ok(c, inst) && src_step == s) begin
                src_step = c;
            end
        end
    endfunction

    // Crest setting; a legal selection pulses the range override.
    // A code outside the two values is refused whole, so ranges stay put.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            crest_reg <= CREST_THREE;
            force_reg <= 1'b0;
        end else begin
            force_reg <= 1'b0;
            if (crest_sel_valid && (crest_sel == CREST_SIX
                                 || crest_sel == CREST_THREE)) begin
                crest_reg <= crest_sel;
                force_reg <= 1'b1;
            end
        end
    end

    // Delay of the external clock for its edge detector.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ext_d_reg <= 1'b0;
        end else begin
            ext_d_reg <= ext_clk_in;
        end
    end

    genvar e;
    generate
        for (e = 0; e < NUM_ELEM; e++) begin : g_elem
            logic signed [SAMPLE_W-1:0] smp;
            logic signed [SAMPLE_W-1:0] hyst;
            logic signed [SAMPLE_W+7:0] rng;
            logic                       hi_reg;
            logic                       xing;
            logic                       seen_reg;
            logic [1:0]                 cnt_reg;
            logic                       whole;

            // Selected source sample for this element.
            always_comb begin
                smp = '0;
                for (int s = 0; s < 2 * NUM_ELEM; s++) begin
                    if (4'(s) == src_reg[e]) begin
                        smp = samples[s*SAMPLE_W +: SAMPLE_W];
                    end
                end
            end

            assign rng  = (SAMPLE_W+8)'(range_full[e*SAMPLE_W +: SAMPLE_W]
                                        * HYST_PCT / PCT_FULL);
            assign hyst = rng[SAMPLE_W-1:0];

            // Schmitt comparator: state flips only beyond the hysteresis band.
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    hi_reg <= 1'b0;
                end else if (sample_valid) begin
                    if (smp > hyst) begin
                        hi_reg <= 1'b1;
                    end else if (smp < -hyst) begin
                        hi_reg <= 1'b0;
                    end
                end
            end

            // Qualifying crossing in the configured direction.
            always_comb begin
                if (src_reg[e] == SRC_EXT) begin
                    xing = falling_edge_sel ? (ext_d_reg && !ext_clk_in)
                                            : (!ext_d_reg && ext_clk_in);
                end else begin
                    xing = sample_valid && (falling_edge_sel
                        ? (hi_reg && smp < -hyst)
                        : (!hi_reg && smp > hyst));
                end
            end

            // Source selection per element or collectively.
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    src_reg[e] <= SRC_NONE;
                end else if ((src_up || src_down)
                          && (target_reg == TGT_ALL
                           || target_reg == 3'(e))) begin
                    src_reg[e] <= mpw_src_type'(src_step(src_reg[e], src_up,
                                                          installed));
                end
            end

            // Whole-interval modes count every sample, crossings or not.
            assign whole = !sync_mode || src_reg[e] == SRC_NONE;

            // Window tracking: sync modes open at the first qualifying
            // crossing, whole-interval modes at once. Crossings are counted
            // up to two; with fewer the consumer falls back to the interval.
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    open_reg[e]  <= 1'b0;
                    start_reg[e] <= 1'b0;
                    close_reg[e] <= 1'b0;
                    full_reg[e]  <= 1'b0;
                    seen_reg     <= 1'b0;
                    cnt_reg      <= 2'h0;
                    peak_reg[e]  <= 1'b0;
                end else begin
                    start_reg[e] <= 1'b0;
                    close_reg[e] <= 1'b0;
                    peak_reg[e]  <= 1'b1;
                    if (update_tick) begin
                        close_reg[e] <= 1'b1;
                        full_reg[e]  <= whole || cnt_reg < 2'h2;
                        start_reg[e] <= 1'b1;
                        open_reg[e]  <= whole;
                        seen_reg     <= 1'b0;
                        cnt_reg      <= 2'h0;
                    end else if (whole) begin
                        open_reg[e] <= 1'b1;
                    end else if (xing) begin
                        seen_reg <= 1'b1;
                        if (!seen_reg) begin
                            open_reg[e] <= 1'b1;
                        end
                        if (cnt_reg != 2'h2) begin
                            cnt_reg <= cnt_reg + 2'h1;
                        end
                    end
                end
            end

            assign window[e] = '{open: open_reg[e], start: start_reg[e],
                                 close: close_reg[e], full: full_reg[e]};
            assign sync_src[e*4 +: 4] = src_reg[e];
        end
    endgenerate

    assign peak_window_open = peak_reg;
    assign target_elem      = target_reg;
    assign crest_ratio      = crest_reg;
    assign force_max_range  = force_reg;

endmodule // mpw_top

// ===== verif/mpw_properties.sv
// Purpose: Timing checks on window, selection and crest outputs.
// Assumes: Element 0 is installed and installed stays fixed.
// Notes:   Bound to mpw_top from the bench top file.
`timescale 1ns/1ps
module mpw_properties
    import mpw_pkg::*;
(
    input wire logic                            sys_clk,
    input wire logic                            reset,
    input wire logic                            update_tick,
    input wire mpw_pkg::mpw_update_type         update_sel,
    input wire logic [mpw_pkg::NUM_ELEM-1:0]    installed,
    input wire logic                            elem_all,
    input wire logic                            crest_sel_valid,
    input wire mpw_pkg::mpw_crest_type          crest_sel,
    input wire mpw_pkg::mpw_win_type [3:0]      window,
    input wire logic [mpw_pkg::NUM_ELEM-1:0]    peak_window_open,
    input wire logic [2:0]                      target_elem,
    input wire logic [mpw_pkg::NUM_ELEM*4-1:0]  sync_src,
    input wire mpw_pkg::mpw_crest_type          crest_ratio,
    input wire logic                            force_max_range
);
    // One clock domain, so clock and reset are stated once here.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_crest_force: assert property (
        crest_sel_valid && crest_sel inside {CREST_THREE, CREST_SIX} |=>
        force_max_range && crest_ratio == $past(crest_sel))
        else $error("crest select did not force ranges");
    chk_crest_legal: assert property (
        crest_ratio inside {CREST_THREE, CREST_SIX})
        else $error("crest setting left its two values");
    chk_tick_close: assert property (
        update_tick && installed[0] |=> window[0].close && window[0].start)
        else $error("interval end gave no window pulses");
    chk_none_full: assert property (
        update_tick && sync_src[3:0] == SRC_NONE |=> window[0].full)
        else $error("no source but window not whole");
    chk_mid_full: assert property (
        update_tick && update_sel inside {[UPD_250MS:UPD_2S]}
        |=> window[0].full)
        else $error("mid interval window not whole");
    chk_peak_whole: assert property (
        !$past(reset) |-> (peak_window_open & installed) == installed)
        else $error("peak window not open");
    chk_all_target: assert property (
        elem_all |=> target_elem == TGT_ALL)
        else $error("all choice not taken");
    chk_target_inst: assert property (
        target_elem == TGT_ALL ||
        (target_elem < 3'h4 && installed[target_elem[1:0]]))
        else $error("target is not an installed element");
endmodule // mpw_properties

// ===== verif/mpw_src_model.sv
// Purpose: Square-wave stand-in for the input channels and ext clock.
// Assumes: Every channel carries the same wave of height amp.
// Notes:   A half period of HALF cycles gives several edges per interval.
`timescale 1ns/1ps
module mpw_src_model
    import mpw_pkg::*;
#(
    parameter int HALF = 10
)
(
    input  wire logic [mpw_pkg::SAMPLE_W-1:0] amp,
    input  wire logic                         sys_clk,
    output logic [mpw_pkg::NUM_ELEM*2*mpw_pkg::SAMPLE_W-1:0] samples,
    output logic                              sample_valid,
    output logic                              ext_clk_in
);
    int   cnt = 0;
    logic ph  = 1'b0;
    // Phase flips just after the edge, so the design sees settled samples.
    always @(posedge sys_clk) begin
        #1;
        cnt = (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == 0) begin
            ph = ~ph;
        end
    end
    // Both halves last HALF cycles, the equal duty the input expects.
    assign ext_clk_in   = ph;
    assign samples      = {(2*NUM_ELEM){ph ? amp : -amp}};
    assign sample_valid = 1'b1;
endmodule // mpw_src_model

// ===== verif/mpw_top_tb_top.sv
// Purpose: Self-checking bench for the measurement window block.
// Assumes: Elements 1, 2 and 4 installed; a tick every 101 cycles.
// Notes:   Range 0x1000 puts the crossing band near 0xCC.
`timescale 1ns/1ps
module mpw_top_tb_top;
    import mpw_pkg::*;
    logic sys_clk, sample_valid, ext_clk_in, force_max_range;
    logic reset = 1, falling_edge_sel = 0, independent = 1;
    logic update_tick = 0, elem_step = 0, elem_all = 0;
    logic src_up = 0, src_down = 0, crest_sel_valid = 0;
    logic [NUM_ELEM*2*SAMPLE_W-1:0] samples;
    logic [NUM_ELEM*SAMPLE_W-1:0]   range_full = {4{16'h1000}};
    logic [NUM_ELEM-1:0]            installed = 4'hB, peak_window_open;
    logic [SAMPLE_W-1:0]            amp = 16'h0800;
    logic [2:0]                     target_elem;
    logic [NUM_ELEM*4-1:0]          sync_src;
    mpw_update_type                 update_sel = UPD_50MS;
    mpw_wire_type                   wiring = WIRE_PAIR;
    mpw_crest_type                  crest_sel = CREST_SIX, crest_ratio;
    mpw_win_type [NUM_ELEM-1:0]     window;
    int n_fail = 0, checks = 0, cyc = 0;
    mpw_src_type dn [7] = '{SRC_EXT, SRC_CURR4, SRC_VOLT4, SRC_CURR2,
                            SRC_VOLT2, SRC_CURR1, SRC_VOLT1};
    logic [2:0] st [5] = '{3'h1, 3'h3, 3'h0, 3'h3, 3'h1};

    mpw_top dut_u (.sys_clk, .reset, .sample_valid, .samples, .range_full,
        .ext_clk_in, .update_tick, .update_sel, .falling_edge_sel,
        .installed, .independent, .wiring, .elem_step, .elem_all, .src_up,
        .src_down, .crest_sel_valid, .crest_sel, .window, .peak_window_open,
        .target_elem, .sync_src, .crest_ratio, .force_max_range);
    mpw_src_model src_u (.amp, .sys_clk, .samples, .sample_valid,
        .ext_clk_in);

    // Pulses last one cycle: raised after an edge, dropped after the next.
    // Only raised pulses are dropped; a repeat pulse waits one more edge.
    task tick_clk;
        @(posedge sys_clk);
        #1;
        if (update_tick) update_tick = 0;
        if (elem_step) elem_step = 0;
        if (elem_all) elem_all = 0;
        if (src_up) src_up = 0;
        if (src_down) src_down = 0;
        if (crest_sel_valid) crest_sel_valid = 0;
    endtask
    task chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One interval of 100 cycles, then the tick and the window flags.
    task run_iv(input logic full, input logic opn);
        repeat (50) tick_clk;
        chk("open", 16'(opn), 16'(window[0].open));
        chk("peak", 16'h000F, 16'(peak_window_open));
        repeat (50) tick_clk;
        update_tick = 1;
        tick_clk;
        chk("close", 16'h0001, 16'(window[0].close));
        chk("full", 16'(full), 16'(window[0].full));
    endtask
    task finish_test;
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Free-running 50 MHz clock.
    initial begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    // A hang is cut short well past the roughly 1850 cycles needed.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test;
        end
    end
    // Main sequence.
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 reset = 0;
        chk("target", 16'h0000, 16'(target_elem));
        chk("src", 16'(SRC_NONE), 16'(sync_src[3:0]));
        chk("crest", 16'(CREST_THREE), 16'(crest_ratio));
        run_iv(1, 1);
        crest_sel_valid = 1;
        tick_clk;
        chk("force", 16'h0001, 16'(force_max_range));
        tick_clk;
        crest_sel = mpw_crest_type'(2'h3);
        crest_sel_valid = 1;
        tick_clk;
        chk("crest", 16'(CREST_SIX), 16'(crest_ratio));
        chk("force", 16'h0000, 16'(force_max_range));
        foreach (dn[i]) begin
            src_down = 1;
            tick_clk;
            chk("src", 16'(dn[i]), 16'(sync_src[3:0]));
            run_iv(0, 1);
        end
        src_up = 1;
        tick_clk;
        chk("src", 16'(SRC_CURR1), 16'(sync_src[3:0]));
        for (int u = 0; u < 8; u++) begin
            update_sel = mpw_update_type'(u);
            run_iv(u inside {[2:5]}, 1);
        end
        update_sel = UPD_50MS;
        amp = 16'h0040;
        run_iv(1, 0);
        amp = 16'h0800;
        falling_edge_sel = 1;
        run_iv(0, 1);
        foreach (st[i]) begin
            independent = (i < 3);
            elem_step = 1;
            tick_clk;
            chk("target", 16'(st[i]), 16'(target_elem));
            tick_clk;
        end
        elem_all = 1;
        elem_step = 1;
        tick_clk;
        chk("target", 16'(TGT_ALL), 16'(target_elem));
        finish_test;
    end
endmodule // mpw_top_tb_top

bind mpw_top mpw_properties chk_u (.sys_clk, .reset, .update_tick,
    .update_sel, .installed, .elem_all, .crest_sel_valid, .crest_sel,
    .window, .peak_window_open, .target_elem, .sync_src, .crest_ratio,
    .force_max_range);
